// ### design/berr_bridge_error_irq.sv
// bridge error interrupt status and enable registers, top level
`timescale 1ns/1ps
module berr_bridge_error_irq (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // register port
    input wire logic i_reg_sel,
    input wire logic i_reg_wr_en,
    input wire logic [berr_pkg::BERR_ADDR_W-1:0] i_reg_addr,
    input wire logic [berr_pkg::BERR_DATA_W-1:0] i_reg_wdata,
    output logic [berr_pkg::BERR_DATA_W-1:0] o_reg_rdata,
    output logic o_reg_ack,
    // error conditions from the bridge datapath, one-cycle or level
    input wire logic i_pci_init_wr_serr,
    input wire logic i_pci_init_rd_serr,
    input wire logic i_retry_fail_timeout,
    input wire logic i_retry_fail_disconnect,
    input wire logic i_retry_fail_retry,
    input wire logic i_master_abort,
    input wire logic i_wr_target_abort,
    input wire logic i_wr_perr,
    input wire logic i_wr_serr,
    input wire logic i_rd_target_abort,
    input wire logic i_rd_perr,
    input wire logic i_rd_serr,
    // global gate and interrupt
    input wire logic i_global_irq_gate,
    output logic o_irq
);
    import berr_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    logic [31:0] raw_events;
    logic [31:0] enable;
    logic [31:0] next_enable;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic ack;
    logic next_ack;
    logic irq;
    logic next_irq;
    logic hit_status;
    logic hit_enable;
    logic wr_status;
    logic wr_enable;
    logic rd_access;

    berr_latch_if lif ();

    // ************************************************************
    // status latch
    // ************************************************************
    berr_status_latch u_latch (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .lif(lif.latch)
    );

    // ************************************************************
    // condition mapping onto msb-first lanes
    // ************************************************************
    // each lane sits at 31 minus its documented position
    always_comb begin
        raw_events = 32'h0000_0000;
        raw_events[berr_lane(BERR_POS_PCI_WR_SERR)] = i_pci_init_wr_serr;
        raw_events[berr_lane(BERR_POS_PCI_RD_SERR)] = i_pci_init_rd_serr;
        raw_events[berr_lane(BERR_POS_RETRY_TIMEOUT)] = i_retry_fail_timeout;
        raw_events[berr_lane(BERR_POS_RETRY_DISCONNECT)] = i_retry_fail_disconnect;
        raw_events[berr_lane(BERR_POS_RETRY_RETRY)] = i_retry_fail_retry;
        raw_events[berr_lane(BERR_POS_MASTER_ABORT)] = i_master_abort;
        raw_events[berr_lane(BERR_POS_WR_TARGET_ABORT)] = i_wr_target_abort;
        raw_events[berr_lane(BERR_POS_WR_PERR)] = i_wr_perr;
        raw_events[berr_lane(BERR_POS_WR_SERR)] = i_wr_serr;
        raw_events[berr_lane(BERR_POS_RD_TARGET_ABORT)] = i_rd_target_abort;
        raw_events[berr_lane(BERR_POS_RD_PERR)] = i_rd_perr;
        raw_events[berr_lane(BERR_POS_RD_SERR)] = i_rd_serr;
    end

    // ************************************************************
    // register decode
    // ************************************************************
    // unmapped offsets are accepted and acked but store nothing
    assign hit_status = (i_reg_addr == BERR_STATUS_OFFSET);
    assign hit_enable = (i_reg_addr == BERR_ENABLE_OFFSET);
    assign wr_status = i_reg_sel & i_reg_wr_en & hit_status;
    assign wr_enable = i_reg_sel & i_reg_wr_en & hit_enable;
    assign rd_access = i_reg_sel & ~i_reg_wr_en;

    // write data only ever clears; masked so reserved lanes stay zero
    assign lif.events = raw_events;
    assign lif.clear_mask = wr_status ? (i_reg_wdata & BERR_ASSIGNED_MASK)
                                      : 32'h0000_0000;

    // ************************************************************
    // enable, read data, ack and interrupt: next values
    // ************************************************************
    always_comb begin
        next_enable = enable;
        if (wr_enable) begin
            next_enable = i_reg_wdata & BERR_ASSIGNED_MASK;
        end
        // read returns the value before any same-cycle update
        next_rdata = 32'h0000_0000;
        if (rd_access && hit_status) begin
            next_rdata = lif.status;
        end else if (rd_access && hit_enable) begin
            next_rdata = enable;
        end
        next_ack = i_reg_sel;
        // registered so the line is glitch free toward the controller
        next_irq = (|(lif.status & enable)) & i_global_irq_gate;
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            enable <= BERR_ENABLE_RESET;
            rdata <= 32'h0000_0000;
            ack <= 1'b0;
            irq <= 1'b0;
        end else begin
            enable <= next_enable;
            rdata <= next_rdata;
            ack <= next_ack;
            irq <= next_irq;
        end
    end

    assign o_reg_rdata = rdata;
    assign o_reg_ack = ack;
    assign o_irq = irq;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    a_event_sets_lane: assert property (
        (raw_events != 32'h0000_0000)
        |=> ((lif.status & $past(raw_events)) == $past(raw_events)))
        else $error("detected condition did not latch");

    a_lane_position: assert property (
        i_pci_init_wr_serr |=> lif.status[12])
        else $error("position 19 not on lane 12");

    a_w1c_clears: assert property (
        (wr_status && ((i_reg_wdata & ~raw_events & lif.status) != 32'h0000_0000))
        |=> ((lif.status & $past(i_reg_wdata) & ~$past(raw_events)) == 32'h0000_0000))
        else $error("write one did not clear");

    a_no_soft_set: assert property (
        ##1 ((lif.status & ~$past(lif.status) & ~$past(raw_events)) == 32'h0000_0000))
        else $error("status bit rose without a condition");

    a_reserved_zero: assert property (
        ((lif.status | enable) & ~BERR_ASSIGNED_MASK) == 32'h0000_0000)
        else $error("unassigned lane is set");

    a_enable_write: assert property (
        wr_enable |=> (enable == ($past(i_reg_wdata) & BERR_ASSIGNED_MASK)))
        else $error("enable write not stored");

    a_masked_no_irq: assert property (
        ((lif.status & enable) == 32'h0000_0000) [*2] |-> !o_irq)
        else $error("interrupt without enabled condition");

    a_gate_blocks: assert property (
        !i_global_irq_gate |=> !o_irq)
        else $error("interrupt passed with gate closed");

    a_irq_follows: assert property (
        (i_global_irq_gate && ((lif.status & enable) != 32'h0000_0000)) |=> o_irq)
        else $error("enabled condition gave no interrupt");

    a_reset_clears: assert property (@(posedge i_clock) disable iff (1'b0)
        i_sys_rst |=> (lif.status == 32'h0000_0000) && (enable == 32'h0000_0000) && !o_irq)
        else $error("reset left bits set");

    a_ack_timing: assert property (
        i_reg_sel |=> o_reg_ack ##1 (o_reg_ack == $past(i_reg_sel)))
        else $error("register ack late or missing");

    a_read_status: assert property (
        (rd_access && hit_status) |=> (o_reg_rdata == $past(lif.status)))
        else $error("status read mismatch");

    // ************************************************************
    // per-condition lane checks
    // ************************************************************
    // one check per condition input except i_pci_init_wr_serr, left to a_lane_position, so a swapped wire shows up by name;
    // the grouped check above proves that every raised lane latched, but names no input
    a_pci_rd_serr: assert property (
        i_pci_init_rd_serr
        |=> lif.status[berr_lane(BERR_POS_PCI_RD_SERR)])
        else $error("pci read serr did not latch");

    a_retry_timeout: assert property (
        i_retry_fail_timeout
        |=> lif.status[berr_lane(BERR_POS_RETRY_TIMEOUT)])
        else $error("retry timeout did not latch");

    a_retry_disconnect: assert property (
        i_retry_fail_disconnect
        |=> lif.status[berr_lane(BERR_POS_RETRY_DISCONNECT)])
        else $error("retry disconnect did not latch");

    a_retry_retry: assert property (
        i_retry_fail_retry
        |=> lif.status[berr_lane(BERR_POS_RETRY_RETRY)])
        else $error("retry on last retry did not latch");

    a_master_abort: assert property (
        i_master_abort
        |=> lif.status[berr_lane(BERR_POS_MASTER_ABORT)])
        else $error("master abort did not latch");

    a_wr_target_abort: assert property (
        i_wr_target_abort
        |=> lif.status[berr_lane(BERR_POS_WR_TARGET_ABORT)])
        else $error("write target abort did not latch");

    a_wr_perr: assert property (
        i_wr_perr
        |=> lif.status[berr_lane(BERR_POS_WR_PERR)])
        else $error("write perr did not latch");

    a_wr_serr: assert property (
        i_wr_serr
        |=> lif.status[berr_lane(BERR_POS_WR_SERR)])
        else $error("write serr did not latch");

    a_rd_target_abort: assert property (
        i_rd_target_abort
        |=> lif.status[berr_lane(BERR_POS_RD_TARGET_ABORT)])
        else $error("read target abort did not latch");

    a_rd_perr: assert property (
        i_rd_perr
        |=> lif.status[berr_lane(BERR_POS_RD_PERR)])
        else $error("read perr did not latch");

    a_rd_serr: assert property (
        i_rd_serr
        |=> lif.status[berr_lane(BERR_POS_RD_SERR)])
        else $error("read serr did not latch");

    // ************************************************************
    // holding checks
    // ************************************************************
    // nothing moves without a write, a reset or a condition;
    // a stray decode would otherwise drop a pending error silently
    a_status_holds: assert property (
        ##1 (($past(lif.status) & ~lif.status & ~$past(lif.clear_mask)) == 32'h0000_0000))
        else $error("status bit fell without a clear");

    a_enable_holds: assert property (
        !wr_enable |=> $stable(enable))
        else $error("enable changed without a write");

    a_read_enable: assert property (
        (rd_access && hit_enable) |=> (o_reg_rdata == $past(enable)))
        else $error("enable read mismatch");

    // reads of unmapped offsets and idle cycles must not leak stale data
    a_rdata_idle_zero: assert property (
        (!rd_access || (!hit_status && !hit_enable)) |=> (o_reg_rdata == 32'h0000_0000))
        else $error("read data not zero outside a mapped read");

    // scenarios worth seeing
    c_irq_raised: cover property (i_global_irq_gate ##1 $rose(o_irq));
    c_set_and_clear: cover property ((lif.events & lif.clear_mask) != 32'h0000_0000);
    c_read_pending: cover property (rd_access && hit_status && (lif.status != 32'h0000_0000));
    // status drops one edge after the write, the line one edge later
    c_clear_drops_irq: cover property (wr_status ##2 $fell(o_irq));

endmodule : berr_bridge_error_irq

// ### design/berr_pkg.sv
// constants and helpers shared by the bridge error interrupt block
package berr_pkg;

    // ************************************************************
    // register port geometry
    // ************************************************************
    localparam int BERR_ADDR_W = 9;
    localparam int BERR_DATA_W = 32;

    // ************************************************************
    // register offsets and reset values
    // ************************************************************
    localparam logic [8:0] BERR_STATUS_OFFSET = 9'h020;
    localparam logic [8:0] BERR_ENABLE_OFFSET = 9'h028;
    localparam logic [31:0] BERR_STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] BERR_ENABLE_RESET = 32'h0000_0000;

    // ************************************************************
    // field positions, numbered msb-first (bit 0 is the data msb)
    // ************************************************************
    localparam int BERR_POS_PCI_WR_SERR = 19;
    localparam int BERR_POS_PCI_RD_SERR = 20;
    localparam int BERR_POS_RETRY_TIMEOUT = 22;
    localparam int BERR_POS_RETRY_DISCONNECT = 23;
    localparam int BERR_POS_RETRY_RETRY = 24;
    localparam int BERR_POS_MASTER_ABORT = 25;
    localparam int BERR_POS_WR_TARGET_ABORT = 26;
    localparam int BERR_POS_WR_PERR = 27;
    localparam int BERR_POS_WR_SERR = 28;
    localparam int BERR_POS_RD_TARGET_ABORT = 29;
    localparam int BERR_POS_RD_PERR = 30;
    localparam int BERR_POS_RD_SERR = 31;
    localparam int BERR_NUM_CONDITIONS = 12;

    // lanes that hold a condition; everything else reads zero
    localparam logic [31:0] BERR_ASSIGNED_MASK = 32'h0000_1BFF;

    // ************************************************************
    // helpers
    // ************************************************************
    // msb-first position to vector index
    function automatic int berr_lane(input int pos);
        return 31 - pos;
    endfunction : berr_lane

endpackage : berr_pkg

// ### design/berr_latch_if.sv
// carrier between the register front end and the status latch
`timescale 1ns/1ps
interface berr_latch_if;
    logic [31:0] events;
    logic [31:0] clear_mask;
    logic [31:0] status;

    // latch side owns the status flops
    modport latch (input events, input clear_mask, output status);
    // front end supplies events and clears
    modport front (output events, output clear_mask, input status);
endinterface : berr_latch_if

// ### design/berr_status_latch.sv
// sticky status flags with write-one-to-clear and set priority
`timescale 1ns/1ps
module berr_status_latch
    import berr_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // events, clears and status
    berr_latch_if.latch lif
);
    import berr_pkg::*;

    logic [31:0] status;
    logic [31:0] next_status;

    // ************************************************************
    // next state: set beats clear in the same cycle
    // ************************************************************
    always_comb begin
        next_status = ((status & ~lif.clear_mask) | lif.events) & BERR_ASSIGNED_MASK;
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            status <= BERR_STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    assign lif.status = status;

    // ************************************************************
    // checks
    // ************************************************************
    a_set_beats_clear: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        ((lif.events & lif.clear_mask) != 32'h0000_0000)
        |=> ((status & $past(lif.events)) == $past(lif.events)))
        else $error("event lost to a same-cycle clear");

endmodule : berr_status_latch

// ### tb/berr_irq_ctrl_model.sv
// interrupt controller stand-in that counts requests raised by the bridge
`timescale 1ns/1ps
module berr_irq_ctrl_model (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // interrupt level from the bridge
    input wire logic i_irq,
    // number of requests taken
    output logic [7:0] o_edges
);
    logic last_irq;

    // a held level is one request only, so count rising edges
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            last_irq <= 1'b0;
            o_edges <= 8'h00;
        end else begin
            last_irq <= i_irq;
            if (i_irq && !last_irq) begin
                o_edges <= o_edges + 8'h01;
            end
        end
    end
endmodule : berr_irq_ctrl_model

// ### tb/tb.sv
// self-checking bench for the bridge error status and enable registers
`timescale 1ns/1ps
module tb;
    import berr_pkg::*;
    // lanes that carry a condition, worked out from positions 19,20,22..31
    localparam logic [31:0] LANES = 32'h0000_1BFF;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic sel = 1'b0;
    logic wr_en = 1'b0;
    logic [8:0] addr = 9'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] ev = 32'h0000_0000;
    logic gate = 1'b0;
    logic [31:0] rdata;
    logic ack;
    logic irq;
    logic [7:0] irq_edges;
    logic [31:0] rd;
    logic [31:0] m;
    int failures = 0;
    int n_tests = 0;

    // ************************************************************
    // clock, design and partner
    // ************************************************************
    initial begin
        forever #2 i_clock = ~i_clock;
    end

    berr_bridge_error_irq i_dut (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_reg_sel(sel), .i_reg_wr_en(wr_en),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
        .i_pci_init_wr_serr(ev[12]), .i_pci_init_rd_serr(ev[11]),
        .i_retry_fail_timeout(ev[9]), .i_retry_fail_disconnect(ev[8]),
        .i_retry_fail_retry(ev[7]), .i_master_abort(ev[6]), .i_wr_target_abort(ev[5]),
        .i_wr_perr(ev[4]), .i_wr_serr(ev[3]), .i_rd_target_abort(ev[2]),
        .i_rd_perr(ev[1]), .i_rd_serr(ev[0]), .i_global_irq_gate(gate), .o_irq(irq)
    );

    berr_irq_ctrl_model i_ctrl (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_irq(irq), .o_edges(irq_edges)
    );

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : cyc

    // one access; request held until the edge that takes it, answer read just after that edge
    task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        cyc(1);
        sel = 1'b1;
        wr_en = w;
        addr = a;
        wdata = d;
        cyc(1);
        sel = 1'b0;
        r = rdata;
        chk("ack", {31'h0000_0000, ack}, 32'h0000_0001);
    endtask : acc

    task automatic pulse(input logic [31:0] mask);
        cyc(1);
        ev = mask;
        cyc(1);
        ev = 32'h0000_0000;
    endtask : pulse

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (16) @(posedge i_clock);
        #1;
        i_sys_rst = 1'b0;
        acc(1'b0, BERR_STATUS_OFFSET, 32'h0000_0000, rd);
        chk("status reset", rd, 32'h0000_0000);
        acc(1'b0, BERR_ENABLE_OFFSET, 32'h0000_0000, rd);
        chk("enable reset", rd, 32'h0000_0000);
        $display("test reset values done");
        // unassigned lanes drop writes; software cannot set status
        acc(1'b1, BERR_ENABLE_OFFSET, 32'hFFFF_FFFF, rd);
        acc(1'b0, BERR_ENABLE_OFFSET, 32'h0000_0000, rd);
        chk("enable lanes", rd, LANES);
        acc(1'b1, BERR_STATUS_OFFSET, 32'hFFFF_FFFF, rd);
        acc(1'b0, BERR_STATUS_OFFSET, 32'h0000_0000, rd);
        chk("status no set", rd, 32'h0000_0000);
        acc(1'b1, 9'h024, 32'hFFFF_FFFF, rd);
        acc(1'b0, 9'h024, 32'h0000_0000, rd);
        chk("unmapped", rd, 32'h0000_0000);
        $display("test access kinds done");
        gate = 1'b1;
        // each condition alone: latch, mask, gate, clear
        for (int l = 0; l < 32; l++) begin
            if (LANES[l]) begin
                m = 32'h0000_0001 << l;
                acc(1'b1, BERR_ENABLE_OFFSET, LANES & ~m, rd);
                pulse(m);
                cyc(2);
                chk("irq masked", {31'h0000_0000, irq}, 32'h0000_0000);
                acc(1'b0, BERR_STATUS_OFFSET, 32'h0000_0000, rd);
                chk("status set", rd, m);
                acc(1'b1, BERR_ENABLE_OFFSET, m, rd);
                cyc(1);
                chk("irq enabled", {31'h0000_0000, irq}, 32'h0000_0001);
                gate = 1'b0;
                cyc(2);
                chk("irq gated", {31'h0000_0000, irq}, 32'h0000_0000);
                gate = 1'b1;
                cyc(2);
                chk("irq ungated", {31'h0000_0000, irq}, 32'h0000_0001);
                acc(1'b1, BERR_STATUS_OFFSET, m, rd);
                acc(1'b0, BERR_STATUS_OFFSET, 32'h0000_0000, rd);
                chk("status clear", rd, 32'h0000_0000);
                chk("irq cleared", {31'h0000_0000, irq}, 32'h0000_0000);
            end
        end
        chk("irq requests", {24'h00_0000, irq_edges}, 32'h0000_0018);
        $display("test conditions done");
        // a new event in the clearing cycle wins, the older bit is cleared
        pulse(32'h0000_0002);
        cyc(1);
        sel = 1'b1;
        wr_en = 1'b1;
        addr = BERR_STATUS_OFFSET;
        wdata = 32'hFFFF_FFFF;
        ev = 32'h0000_0001;
        cyc(1);
        sel = 1'b0;
        ev = 32'h0000_0000;
        acc(1'b0, BERR_STATUS_OFFSET, 32'h0000_0000, rd);
        chk("set wins", rd, 32'h0000_0001);
        $display("test set priority done");
        // reset in mid-run clears both registers
        acc(1'b1, BERR_ENABLE_OFFSET, LANES, rd);
        i_sys_rst = 1'b1;
        cyc(2);
        i_sys_rst = 1'b0;
        acc(1'b0, BERR_STATUS_OFFSET, 32'h0000_0000, rd);
        chk("status rerst", rd, 32'h0000_0000);
        acc(1'b0, BERR_ENABLE_OFFSET, 32'h0000_0000, rd);
        chk("enable rerst", rd, 32'h0000_0000);
        $display("test second reset done");
        tally_and_finish();
    end

    // watchdog, far beyond the roughly 280 cycles the tests need
    initial begin
        #40000;
        failures++;
        tally_and_finish();
    end
endmodule : tb
